// file: src/press_opt_pkg.sv
// Constants, types and register map of the option switch logic.
// Assumes a 10 MHz system clock and switches that read 1 when closed.
package press_opt_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_MS = 1;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int ANG_W = 9;
    localparam int CNT_W = 20;
    localparam int ADDR_W = 8;
    localparam int SYNC_W = 23;
    // Window lengths in seconds, then in millisecond ticks
    localparam int LC_HOLD_S = 8;
    localparam int PA_SS_OPEN_S = 30;
    localparam int PA_COD_OPEN_S = 60;
    localparam int PA_SS_CLOSED_S = 300;
    localparam int PA_COD_CLOSED_S = 600;
    localparam logic [CNT_W-1:0] LC_HOLD_TICKS = CNT_W'(LC_HOLD_S * MS_PER_S);
    localparam logic [CNT_W-1:0] PA_SS_OPEN = CNT_W'(PA_SS_OPEN_S * MS_PER_S);
    localparam logic [CNT_W-1:0] PA_COD_OPEN = CNT_W'(PA_COD_OPEN_S * MS_PER_S);
    localparam logic [CNT_W-1:0] PA_SS_LONG = CNT_W'(PA_SS_CLOSED_S * MS_PER_S);
    localparam logic [CNT_W-1:0] PA_COD_LONG = CNT_W'(PA_COD_CLOSED_S * MS_PER_S);
    // Crank angles in degrees, then the switch capture delay in clock cycles
    localparam logic [ANG_W-1:0] TS_FLOOR = 9'h0D3;
    localparam logic [ANG_W-1:0] TS_BASE_RST = 9'h0D3;
    localparam logic [ANG_W-1:0] OVS_LIMIT = 9'h0B4;
    localparam logic [ANG_W-1:0] CARRY_UP_ANG = 9'h0B4;
    localparam logic [ANG_W-1:0] COMP_STEP = 9'h002;
    localparam logic [ANG_W-1:0] TEST_ANG_R0 = 9'h0D2;
    localparam logic [ANG_W-1:0] TEST_ANG_R1 = 9'h0F1;
    localparam logic [ANG_W-1:0] TEST_ANG_R2 = 9'h10F;
    localparam logic [ANG_W-1:0] TEST_ANG_R3 = 9'h12D;
    localparam logic [1:0] CAP_DELAY = 2'h3;
    // Register map
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_BASE = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SWITCH = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_TSANG = 8'h10;
    localparam int CTRL_SINGLE = 2;
    localparam int CTRL_CLR = 4;
    localparam int CTRL_REARM = 5;
    localparam logic [2:0] CTRL_RST = 3'h4;
    // Option switch positions
    localparam int SW_R1 = 0;
    localparam int SW_R2 = 1;
    localparam int SW_GATE = 2;
    localparam int SW_COMP = 3;
    localparam int SW_LONG = 4;
    localparam int SW_DUAL = 5;
    typedef enum logic [1:0] {
        M_ONE_HAND = 2'h0,
        M_FOOT = 2'h1,
        M_AUTO_SS = 2'h2,
        M_AUTO_COD = 2'h3
    } mode_t;
    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_RUN = 4'h2,
        S_CARRY = 4'h4,
        S_HALT = 4'h8
    } state_t;
endpackage

// file: src/tmr_if.sv
// Control and status of one window timer.
// Assumes one controller and one timer per instance.
`timescale 1ns/1ps
interface tmr_if #(parameter int W = 20);
    logic start;
    logic clear;
    logic [W-1:0] limit;
    logic running;
    logic done;
    modport ctl(output start, output clear, output limit,
                input running, input done);
    modport tmr(input start, input clear, input limit,
                output running, output done);
endinterface

// file: src/sync2.sv
// Two flip-flop synchroniser for a bundle of pin levels.
// Assumes the bundle may be skewed by one cycle between bits.
`timescale 1ns/1ps
module sync2 #(parameter int W = 1) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// file: src/window_timer.sv
// Window timer counting millisecond ticks up to a limit.
// Assumes start and clear are never high together.
`timescale 1ns/1ps
module window_timer #(parameter int W = 20) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    tmr_if.tmr t
);
    logic [W-1:0] cnt;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= '0;
            t.running <= 1'b0;
            t.done <= 1'b0;
        end else begin
            t.done <= 1'b0;
            if (t.start) begin
                cnt <= '0;
                t.running <= 1'b1;
            end else if (t.clear) begin
                t.running <= 1'b0;
            end else if (t.running && tick) begin
                if (cnt + W'(1) >= t.limit) begin
                    t.running <= 1'b0;
                    t.done <= 1'b1;
                end
                cnt <= cnt + W'(1);
            end
        end
    end

    a_timer_count: assert property (@(posedge clk) disable iff (!rst_n)
        t.running |-> cnt < t.limit)
        else $error("window timer ran past its limit");
endmodule

// file: src/press_option_logic.sv
// Option switch decode and stroke gating for a press control.
// Assumes pins are asynchronous and switches read 1 when closed.
//
// Notes on behaviour
// - New switch settings act only after a power cycle.
// - Switches 1 and 2 pick one of four top-stop angle ranges.
// - The chosen range sets where the overrun closure test begins.
// - Switch 3 open: one-hand press starts a stroke at any time.
// - Switch 3 closed: one-hand works from curtain break to 8 s after clear.
// - After that window expires, a new curtain break is needed.
// - Foot trip: one press of the foot switch completes a stroke.
// - Foot hold: release before carry-up angle gives an emergency stop.
// - Foot trip or hold choice applies to single-stroke only.
// - Switch 4 closed enables speed-compensated top-stop, else off.
// - Overshoot past 360 moves the top-stop earlier by that amount.
// - Compensated top-stop never goes earlier than 211 degrees.
// - Compensation moves in small steps over several top-stops.
// - Switch 5 picks 30 s/1 min or 5 min/10 min request windows.
// - Switch 6 closed monitors both light curtains, else only one.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module press_option_logic
    import press_opt_pkg::*;
#(
    parameter int TICK_CYCLES = MS_CYCLES
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Register port
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [31:0] WR_DATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [31:0] RD_DATA,
    // Pins
    input wire logic [7:0] OPT_SW,
    input wire logic ONE_HAND_PB,
    input wire logic FOOT_SW,
    input wire logic [1:0] CURTAIN_BRK,
    input wire logic AUTO_ACT,
    input wire logic STOP_DONE,
    input wire logic [ANG_W-1:0] ANGLE,
    // Press outputs
    output logic STROKE_REQ,
    output logic ESTOP,
    output logic TEST_ARM,
    output logic [ANG_W-1:0] TOP_STOP_ANGLE,
    output logic [1:0] CURTAIN_MON
);
    logic [SYNC_W-1:0] pins_q;
    logic [7:0] sw;
    logic [1:0] cap_cnt;
    logic sampled;
    logic oh_q, foot_q, act_q, stop_q, brk_q;
    logic oh_prev, foot_prev, act_prev, stop_prev, brk_prev;
    logic oh_rise, foot_rise, act_rise, stop_evt, brk_rise, brk_fall;
    logic [ANG_W-1:0] angle_q;
    logic [ANG_W-1:0] base;
    logic [2:0] ctrl;
    mode_t mode;
    state_t state, next_state;
    logic hold;
    logic go;
    logic lc_win;
    logic pa_rearm, estop_clr;
    logic [1:0] range;
    logic [ANG_W-1:0] test_start;
    logic [ANG_W-1:0] target;
    // One spare bit keeps the divider legal for a one-cycle tick
    localparam int DIV_W = $clog2(TICK_CYCLES + 1);
    logic [DIV_W-1:0] div;
    logic tick;
    tmr_if #(CNT_W) lc_t ();
    tmr_if #(CNT_W) pa_t ();

    sync2 #(.W(SYNC_W)) u_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .d({OPT_SW[7:0], ONE_HAND_PB, FOOT_SW, AUTO_ACT, STOP_DONE,
            CURTAIN_BRK[1:0], ANGLE[ANG_W-1:0]}),
        .q(pins_q)
    );
    window_timer #(.W(CNT_W)) u_lc_tmr (
        .clk(CLK),
        .rst_n(RST_N),
        .tick(tick),
        .t(lc_t)
    );
    window_timer #(.W(CNT_W)) u_pa_tmr (
        .clk(CLK),
        .rst_n(RST_N),
        .tick(tick),
        .t(pa_t)
    );

    // Millisecond tick for the window timers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            div <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (div == DIV_W'(TICK_CYCLES - 1));
            if (div == DIV_W'(TICK_CYCLES - 1))
                div <= '0;
            else
                div <= div + 1'b1;
        end
    end

    // Capture once after the synchroniser has filled
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cap_cnt <= '0;
            sampled <= 1'b0;
            sw <= '0;
        end else if (!sampled) begin
            cap_cnt <= cap_cnt + 1'b1;
            if (cap_cnt == CAP_DELAY) begin
                sw <= pins_q[SYNC_W-1 -: 8];
                sampled <= 1'b1;
            end
        end
    end

    // Edge detection on synchronised inputs
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            {oh_prev, foot_prev, act_prev, stop_prev, brk_prev} <= '0;
            {oh_q, foot_q, act_q, stop_q, brk_q} <= '0;
            angle_q <= '0;
        end else begin
            oh_q <= pins_q[ANG_W+5];
            foot_q <= pins_q[ANG_W+4];
            act_q <= pins_q[ANG_W+3];
            stop_q <= pins_q[ANG_W+2];
            // Second curtain counts only when enabled
            brk_q <= pins_q[ANG_W] | (sw[SW_DUAL] & pins_q[ANG_W+1]);
            angle_q <= pins_q[ANG_W-1:0];
            {oh_prev, foot_prev, act_prev, stop_prev, brk_prev} <=
                {oh_q, foot_q, act_q, stop_q, brk_q};
        end
    end
    assign oh_rise = oh_q & ~oh_prev;
    assign foot_rise = foot_q & ~foot_prev;
    assign act_rise = act_q & ~act_prev;
    assign stop_evt = stop_q & ~stop_prev;
    assign brk_rise = brk_q & ~brk_prev;
    assign brk_fall = ~brk_q & brk_prev;
    assign mode = mode_t'(ctrl[1:0]);

    // Register writes; clear and rearm are one-cycle pulses
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctrl <= CTRL_RST;
            base <= TS_BASE_RST;
            estop_clr <= 1'b0;
            pa_rearm <= 1'b0;
        end else begin
            estop_clr <= 1'b0;
            pa_rearm <= 1'b0;
            if (WR_EN && ADDR == REG_CTRL) begin
                ctrl <= WR_DATA[2:0];
                estop_clr <= WR_DATA[CTRL_CLR];
                pa_rearm <= WR_DATA[CTRL_REARM];
            end else if (WR_EN && ADDR == REG_BASE) begin
                base <= WR_DATA[ANG_W-1:0];
            end
        end
    end

    // Reads answer in the next cycle only; unmapped reads give zero
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            RD_DATA <= '0;
        end else if (!RD_EN) begin
            RD_DATA <= '0;
        end else if (ADDR == REG_CTRL) begin
            RD_DATA <= {29'h0, ctrl};
        end else if (ADDR == REG_BASE) begin
            RD_DATA <= {23'h0, base};
        end else if (ADDR == REG_SWITCH) begin
            RD_DATA <= {24'h0, sw};
        end else if (ADDR == REG_STATUS) begin
            RD_DATA <= {23'h0, range, ESTOP, pa_t.running, lc_win, state};
        end else if (ADDR == REG_TSANG) begin
            RD_DATA <= {23'h0, TOP_STOP_ANGLE};
        end else begin
            RD_DATA <= '0;
        end
    end

    // Closed reads 1, so the range is the inverted pair
    assign range = {~sw[SW_R1], ~sw[SW_R2]};

    // Closure test starts at the low edge of the range
    always_comb begin
        case (range)
            2'h0: test_start = TEST_ANG_R0;
            2'h1: test_start = TEST_ANG_R1;
            2'h2: test_start = TEST_ANG_R2;
            default: test_start = TEST_ANG_R3;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            TEST_ARM <= 1'b0;
            CURTAIN_MON <= '0;
        end else begin
            TEST_ARM <= (state != S_IDLE) && (angle_q >= test_start);
            CURTAIN_MON <= {sw[SW_DUAL], 1'b1};
        end
    end

    // Window opens on a break, closes 8 s after clear
    assign lc_t.start = brk_fall & lc_win;
    assign lc_t.clear = brk_rise | (go & (mode == M_ONE_HAND));
    assign lc_t.limit = LC_HOLD_TICKS;

    // Expiry or a used window needs a new break
    always_ff @(posedge CLK) begin
        if (!RST_N)
            lc_win <= 1'b0;
        else if (brk_rise)
            lc_win <= 1'b1;
        else if (lc_t.done || (go && mode == M_ONE_HAND))
            lc_win <= 1'b0;
    end

    // Request window length by stroke kind and switch 5
    always_comb begin
        if (mode == M_AUTO_SS)
            pa_t.limit = sw[SW_LONG] ? PA_SS_LONG : PA_SS_OPEN;
        else
            pa_t.limit = sw[SW_LONG] ? PA_COD_LONG : PA_COD_OPEN;
    end
    // Window armed on return to idle or by software
    assign pa_t.start = pa_rearm |
        (mode[1] && state != S_IDLE && next_state == S_IDLE);
    assign pa_t.clear = go & mode[1];

    always_comb begin
        case (mode)
            M_ONE_HAND: go = oh_rise & (~sw[SW_GATE] | lc_win);
            M_FOOT: go = foot_rise;
            default: go = act_rise & pa_t.running;
        endcase
        if (state != S_IDLE || !sampled)
            go = 1'b0;
    end

    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: if (go) next_state = S_RUN;
            S_RUN: begin
                // Early release of a held foot switch
                if (hold && !foot_q && angle_q < CARRY_UP_ANG)
                    next_state = S_HALT;
                else if (angle_q >= CARRY_UP_ANG)
                    next_state = S_CARRY;
                else if (stop_evt)
                    next_state = S_IDLE;
            end
            S_CARRY: if (stop_evt) next_state = S_IDLE;
            S_HALT: if (estop_clr) next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state <= S_IDLE;
            hold <= 1'b0;
            STROKE_REQ <= 1'b0;
            ESTOP <= 1'b0;
        end else begin
            state <= next_state;
            STROKE_REQ <= go;
            ESTOP <= (next_state == S_HALT);
            // Hold applies to single-stroke foot only
            if (go)
                hold <= (mode == M_FOOT) && ctrl[CTRL_SINGLE] &&
                        sw[SW_GATE];
        end
    end

    // Overshoot pulls the target earlier, floor held
    always_comb begin
        target = base;
        if (angle_q != '0 && angle_q < OVS_LIMIT) begin
            if (base > TS_FLOOR + angle_q)
                target = base - angle_q;
            else
                target = TS_FLOOR;
        end
        if (target < TS_FLOOR)
            target = TS_FLOOR;
    end

    // Step toward target once per top-stop
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            TOP_STOP_ANGLE <= TS_BASE_RST;
        end else if (!sw[SW_COMP]) begin
            TOP_STOP_ANGLE <= base;
        end else if (stop_evt) begin
            if (TOP_STOP_ANGLE > target + COMP_STEP)
                TOP_STOP_ANGLE <= TOP_STOP_ANGLE - COMP_STEP;
            else if (TOP_STOP_ANGLE + COMP_STEP < target)
                TOP_STOP_ANGLE <= TOP_STOP_ANGLE + COMP_STEP;
            else
                TOP_STOP_ANGLE <= target;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_held_start;
        go && mode == M_FOOT && ctrl[CTRL_SINGLE] && sw[SW_GATE];
    endsequence
    sequence s_early_release;
        state == S_RUN && hold && !foot_q && angle_q < CARRY_UP_ANG;
    endsequence

    a_switch_frozen: assert property (
        sampled |=> $stable(sw))
        else $error("latched switches changed after capture");
    a_range_start: assert property (
        (sw[SW_R1] && sw[SW_R2]) |-> test_start == TEST_ANG_R0)
        else $error("closure test start wrong for lowest range");
    a_gate_refuse: assert property (
        (state == S_IDLE && mode == M_ONE_HAND && sw[SW_GATE] && !lc_win)
        |=> !STROKE_REQ)
        else $error("one-hand stroke outside curtain window");
    a_hold_estop: assert property (
        s_early_release |=> ESTOP && state == S_HALT)
        else $error("early foot release did not stop");
    a_hold_arm: assert property (
        s_held_start |=> hold)
        else $error("foot hold not armed for single-stroke");
    a_trip_nohold: assert property (
        (go && !ctrl[CTRL_SINGLE]) |=> !hold)
        else $error("hold set outside single-stroke");
    a_comp_off: assert property (
        !sw[SW_COMP] |=> TOP_STOP_ANGLE == $past(base))
        else $error("top-stop moved with compensation off");
    a_comp_floor: assert property (
        sampled |-> TOP_STOP_ANGLE >= TS_FLOOR || !sw[SW_COMP])
        else $error("top-stop earlier than floor");
    a_comp_step: assert property (
        (sw[SW_COMP] && stop_evt && TOP_STOP_ANGLE > target + COMP_STEP)
        |=> TOP_STOP_ANGLE == $past(TOP_STOP_ANGLE) - COMP_STEP)
        else $error("compensation step wrong");
    a_auto_refuse: assert property (
        (state == S_IDLE && mode[1] && !pa_t.running) |=> !STROKE_REQ)
        else $error("auto stroke outside request window");
    a_req_pulse: assert property (
        STROKE_REQ |-> state == S_RUN ##1 !STROKE_REQ)
        else $error("stroke request not a single pulse");
endmodule

// file: tb/press_far_side.sv
// Far side of the press control: crank, brake coast and stop feedback.
// Assumes one stroke request pulse per stroke; crank turns 4 degrees a cycle.
`timescale 1ns/1ps
module press_far_side
    import press_opt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // From the control
    input wire logic stroke_req,
    input wire logic estop,
    // Commanded coast past top
    input wire logic [ANG_W-1:0] over,
    // To the control; busy goes to the bench
    output logic [ANG_W-1:0] angle,
    output logic stop_done,
    output logic busy
);
    logic run;
    logic [3:0] hold;

    // Angle settles four cycles before the stop edge
    assign stop_done = (hold != 4'h0) && (hold < 4'h4);
    assign busy = run || (hold != 4'h0);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            angle <= 9'h000;
            run <= 1'b0;
            hold <= 4'h0;
        end else if (run && estop) begin
            run <= 1'b0;
        end else if (stroke_req) begin
            run <= 1'b1;
        end else if (run) begin
            if ({1'b0, angle} + 10'h004 >= 10'h168) begin
                angle <= over;
                run <= 1'b0;
                hold <= 4'h7;
            end else begin
                angle <= angle + 9'h004;
            end
        end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
        end
    end
endmodule

// file: tb/press_option_switch_logic_bench.sv
// Self-checking bench of the option switch logic.
// Assumes a 1-cycle tick so that the timed windows fit the run.
`timescale 1ns/1ps
module press_option_switch_logic_bench
    import press_opt_pkg::*;
;
    typedef struct packed {
        logic [7:0] sw;
        logic [1:0] rng;
        logic [8:0] start;
        logic [1:0] mon;
    } row_t;
    row_t rows [4] = '{'{8'h03, 2'h0, 9'h0D2, 2'h1},
        '{8'h61, 2'h1, 9'h0F1, 2'h3}, '{8'h22, 2'h2, 9'h10F, 2'h3},
        '{8'h40, 2'h3, 9'h12D, 2'h1}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] opt_sw = 8'h00;
    logic one_hand = 1'b0;
    logic foot = 1'b0;
    logic [1:0] brk = 2'h0;
    logic act = 1'b0;
    logic [8:0] over = 9'h000;
    logic [31:0] rd_data;
    logic [8:0] angle, ts_ang;
    logic [8:0] arm_ang = 9'h000;
    logic [1:0] mon;
    logic stop_done, req, estop, arm, busy, arm_q;
    int miscompares = 0;
    int checks = 0;

    press_option_logic #(.TICK_CYCLES(1)) i_dut (.CLK(clk), .RST_N(rst_n),
        .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en),
        .RD_DATA(rd_data), .OPT_SW(opt_sw), .ONE_HAND_PB(one_hand),
        .FOOT_SW(foot), .CURTAIN_BRK(brk), .AUTO_ACT(act),
        .STOP_DONE(stop_done), .ANGLE(angle), .STROKE_REQ(req),
        .ESTOP(estop), .TEST_ARM(arm), .TOP_STOP_ANGLE(ts_ang),
        .CURTAIN_MON(mon));
    press_far_side i_far (.clk(clk), .rst_n(rst_n), .stroke_req(req),
        .estop(estop), .over(over), .angle(angle), .stop_done(stop_done),
        .busy(busy));

    initial begin
        forever #50 clk = ~clk;
    end

    // Angle seen when the closure test arms
    always @(posedge clk) begin
        if (!rst_n) begin
            arm_ang <= 9'h000;
        end else if (arm === 1'b1 && arm_q !== 1'b1) begin
            arm_ang <= angle;
        end
        arm_q <= arm;
    end

    task check(input string n, input logic [31:0] seen, input logic [31:0] e);
        checks++;
        if (seen !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, seen);
        end
    endtask

    task conclude;
        $display("Checks %0d, mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
            input string n);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 check(n, rd_data & m, e);
    endtask

    task rst(input logic [7:0] sw);
        @(posedge clk);
        rst_n <= 1'b0;
        opt_sw <= sw;
        cyc(5);
        rst_n <= 1'b1;
        cyc(12);
    endtask

    task pin(input int k, input logic v);
        case (k)
            0: one_hand <= v;
            1: foot <= v;
            default: act <= v;
        endcase
    endtask

    task wait_idle;
        for (int i = 0; i < 500 && busy !== 1'b0; i++) cyc(1);
        cyc(12);
    endtask

    // Rel 1 lets go after 6 cycles, 0 holds, 2 holds and returns at once
    task go(input int k, input logic e, input int rel);
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        pin(k, 1'b1);
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            if (i == 5 && rel == 1) pin(k, 1'b0);
            #1 if (req === 1'b1) seen = 1'b1;
        end
        check("stroke", seen, e);
        if (seen && rel != 2) wait_idle;
    endtask

    // Lift the foot well before carry-up
    task drop;
        for (int i = 0; i < 100 && angle < 9'h064; i++) cyc(1);
        foot <= 1'b0;
        cyc(10);
    endtask

    initial begin
        for (int r = 0; r < 4; r++) begin
            rst(rows[r].sw);
            rc(REG_SWITCH, {26'h0, rows[r].sw[5:0]}, 32'h3F, "sw");
            rc(REG_STATUS, {23'h0, rows[r].rng, 7'h0}, 32'h180, "rng");
            check("mon", mon, rows[r].mon);
            go(0, 1'b1, 1);
            check("arm", arm_ang >= rows[r].start
                && arm_ang <= rows[r].start + 9'h018, 1);
            opt_sw <= ~rows[r].sw;
            cyc(10);
            rc(REG_SWITCH, {26'h0, rows[r].sw[5:0]}, 32'h3F, "kept");
            check("mon kept", mon, rows[r].mon);
        end
        rst(8'h00);
        check("ts reset", ts_ang, 9'h0D3);
        rc(REG_CTRL, 32'h4, 32'h7, "ctrl");
        rc(8'h14, 32'h0, 32'hFFFFFFFF, "unmapped");
        wr(REG_BASE, 32'h12C);
        over <= 9'h006;
        go(0, 1'b1, 1);
        check("comp off", ts_ang, 9'h12C);
        // Climbs from 211 to base less overshoot, then down to the floor
        rst(8'h08);
        wr(REG_BASE, 32'hE1);
        for (int s = 0; s < 9; s++) begin
            if (s == 5) wr(REG_BASE, 32'hD7);
            go(0, 1'b1, 1);
            check("comp", ts_ang, s > 4 ? 9'h0E3 - 9'(2 * s) :
                (s > 3 ? 9'h0DB : 9'h0D5 + 9'(2 * s)));
        end
        check("floor", ts_ang, 9'h0D3);
        rst(8'h24);
        brk <= 2'b10;
        cyc(5);
        go(0, 1'b1, 1);
        rst(8'h04);
        brk <= 2'b10;
        cyc(5);
        go(0, 1'b0, 1);
        brk <= 2'b01;
        cyc(5);
        go(0, 1'b1, 1);
        brk <= 2'b00;
        cyc(5);
        brk <= 2'b01;
        cyc(5);
        brk <= 2'b00;
        cyc(7900);
        go(0, 1'b1, 1);
        brk <= 2'b01;
        cyc(5);
        brk <= 2'b00;
        cyc(8100);
        go(0, 1'b0, 1);
        over <= 9'h003;
        rst(8'h00);
        wr(REG_CTRL, 32'h5);
        go(1, 1'b1, 1);
        check("trip", {estop, angle}, 10'h003);
        rst(8'h04);
        wr(REG_CTRL, 32'h5);
        go(1, 1'b1, 0);
        foot <= 1'b0;
        cyc(10);
        check("held", estop, 1'b0);
        go(1, 1'b1, 2);
        drop;
        check("early", estop, 1'b1);
        wait_idle;
        wr(REG_CTRL, 32'h15);
        cyc(3);
        check("cleared", estop, 1'b0);
        wr(REG_CTRL, 32'h1);
        go(1, 1'b1, 2);
        drop;
        check("cont", estop, 1'b0);
        wait_idle;
        rst(8'h00);
        wr(REG_CTRL, 32'h6);
        go(2, 1'b0, 1);
        wr(REG_CTRL, 32'h27);
        go(2, 1'b1, 1);
        wr(REG_CTRL, 32'h26);
        cyc(29900);
        go(2, 1'b1, 1);
        cyc(30100);
        go(2, 1'b0, 1);
        conclude;
    end

    // Tests take about 80000 cycles
    initial begin
        cyc(95000);
        miscompares++;
        conclude;
    end
endmodule
